// ### core/sfd_map.vh
`ifndef SFD_MAP_VH
`define SFD_MAP_VH
`define SFD_OP_WR_EN     8'h06
`define SFD_OP_VOL_EN    8'h50
`define SFD_OP_WR_DIS    8'h04
`define SFD_OP_RD_ST1    8'h05
`define SFD_OP_RD_ST2    8'h35
`define SFD_OP_WR_ST     8'h01
`define SFD_OP_PROG      8'h02
`define SFD_OP_QPROG     8'h32
`define SFD_OP_ERA4K     8'h20
`define SFD_OP_ERA32K    8'h52
`define SFD_OP_ERA64K    8'hD8
`define SFD_OP_CHIP_A    8'hC7
`define SFD_OP_CHIP_B    8'h60
`define SFD_OP_SUSP      8'h75
`define SFD_OP_RESUME    8'h7A
`define SFD_OP_PDOWN     8'hB9
`define SFD_OP_CRM_RST   8'hFF
`define SFD_OP_RD        8'h03
`define SFD_OP_FRD       8'h0B
`define SFD_OP_FRD_DO    8'h3B
`define SFD_OP_FRD_QO    8'h6B
`define SFD_OP_FRD_DIO   8'hBB
`define SFD_OP_FRD_QIO   8'hEB
`define SFD_OP_WRD_QIO   8'hE7
`define SFD_OP_OWRD_QIO  8'hE3
`define SFD_OP_WRAP      8'h77
`define SFD_OP_ID_REL    8'hAB
`define SFD_OP_ID_MF     8'h90
`define SFD_OP_ID_MF2    8'h92
`define SFD_OP_ID_MF4    8'h94
`define SFD_OP_JID       8'h9F
`define SFD_REG_OPC      8'h00
`define SFD_REG_ADDR     8'h04
`define SFD_REG_STAT     8'h08
`define SFD_REG_CTRL     8'h0C
`define SFD_REG_FILL     8'h10
`define SFD_CTRL_DONE    0
`define SFD_BP_LO        2
`define SFD_BP_HI        4
`define SFD_TBOT         5
`define SFD_GRAN         6
`define SFD_INV          14
`define SFD_WSR_MASK     16'h7BFC
`define SFD_OTP_MASK     16'h3800
`define SFD_STAT_RST     16'h0000
`define SFD_FILL_RST     8'hFF
`define SFD_SYNC_RST     6'h30
`endif

// ### core/sfd_core.v
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "sfd_map.vh"
// Function
// - select going low starts a frame; first byte shifted in is the opcode.
// - inputs sampled on clock rise; all bytes travel msb first.
// - select rising ends a frame; address is three bytes, high first.
// - a read may stop after any bit without any error.
// - write, program, erase only act when a whole number of bytes arrived.
// - while busy, every opcode but a status read is ignored.
// - a status read repeats the selected byte until select rises.
// - single-byte write enable, volatile write enable and write disable.
// - low status read, high status read, two-byte status write low first.
// - sector, 32KB and 64KB erase at an address; chip erase by two opcodes.
// - page program on one line; quad program sends nibbles high first.
// - single-byte suspend, resume and power-down opcodes.
// - plain read has data after address; fast read adds one dummy byte.
// - dual/quad output reads use one dummy byte; dual io sends address on two.
// - quad io reads take address on four lines, with 4, 2, 0 dummy nibbles.
// - wrap setting takes six dummy nibbles, then the wrap length nibble.
// - inverted protection: range 000 protects all, 111 protects nothing.
// - erase or program touching any protected part is silently ignored.
// - four id opcodes return a device code; one returns maker and type.
// - the invert bit flips the protected region; reset value zero.
// - write latch clears after reset and when a write operation completes.
module sfd_core #(
	parameter [7:0]  MFR_ID   = 8'h5A,	// arbitrary value
	parameter [7:0]  DEV_ID   = 8'h3C,	// arbitrary value
	parameter [15:0] TYPE_CAP = 16'h1234	// arbitrary value
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cs_n_i,
	input  wire        sclk_i,
	input  wire [3:0]  quad_line_i,
	output wire [3:0]  quad_line_o,
	output wire [3:0]  quad_line_oe_n_o,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o
);

localparam [9:0] S_OPC  = 10'h001;
localparam [9:0] S_ADR  = 10'h002;
localparam [9:0] S_MOD  = 10'h004;
localparam [9:0] S_DUM  = 10'h008;
localparam [9:0] S_WRP  = 10'h010;
localparam [9:0] S_DIN  = 10'h020;
localparam [9:0] S_WSR  = 10'h040;
localparam [9:0] S_OUT  = 10'h080;
localparam [9:0] S_TAIL = 10'h100;
localparam [9:0] S_IGN  = 10'h200;
// final-phase codes are bit positions of the one-hot states
localparam [3:0] F_WRP  = 4'd4;
localparam [3:0] F_DIN  = 4'd5;
localparam [3:0] F_WSR  = 4'd6;
localparam [3:0] F_OUT  = 4'd7;
localparam [3:0] F_TAIL = 4'd8;
localparam [3:0] F_IGN  = 4'd9;

function [23:0] shin;
	input [23:0] a;
	input [3:0]  l;
	input [1:0]  w;
	begin
		case (w)
		2'd0: shin = {a[22:0], l[0]};
		2'd1: shin = {a[21:0], l[1:0]};
		default: shin = {a[19:0], l};
		endcase
	end
endfunction

function [3:0] obits;
	input [7:0] b;
	input [1:0] w;
	begin
		case (w)
		2'd0: obits = {2'b00, b[7], 1'b0};
		2'd1: obits = {2'b00, b[7:6]};
		default: obits = b[7:4];
		endcase
	end
endfunction

function [7:0] shl;
	input [7:0] b;
	input [1:0] w;
	begin
		case (w)
		2'd0: shl = {b[6:0], 1'b0};
		2'd1: shl = {b[5:0], 2'b00};
		default: shl = {b[3:0], 4'h0};
		endcase
	end
endfunction

function [2:0] wbits;
	input [1:0] w;
	begin
		case (w)
		2'd0: wbits = 3'd1;
		2'd1: wbits = 3'd2;
		default: wbits = 3'd4;
		endcase
	end
endfunction

function [15:0] dsc;
	input integer a;
	input integer m;
	input integer aw;
	input integer dw;
	input integer dum;
	input [3:0]   fin;
	begin
		// table entries are plain numbers; only the low bits of each field are kept
		dsc = {a[0], m[0], aw[1:0], dw[1:0], dum[5:0], fin};
	end
endfunction

// descriptor: address, mode, address width, data width, dummy cycles, final phase
function [15:0] decode;
	input [7:0] op;
	begin
		case (op)
		`SFD_OP_WR_EN, `SFD_OP_VOL_EN, `SFD_OP_WR_DIS: decode = dsc(0, 0, 0, 0, 0, F_TAIL);
		`SFD_OP_SUSP, `SFD_OP_RESUME, `SFD_OP_PDOWN: decode = dsc(0, 0, 0, 0, 0, F_TAIL);
		`SFD_OP_CHIP_A, `SFD_OP_CHIP_B, `SFD_OP_CRM_RST: decode = dsc(0, 0, 0, 0, 0, F_TAIL);
		`SFD_OP_RD_ST1, `SFD_OP_RD_ST2: decode = dsc(0, 0, 0, 0, 0, F_OUT);
		`SFD_OP_WR_ST: decode = dsc(0, 0, 0, 0, 0, F_WSR);
		`SFD_OP_PROG: decode = dsc(1, 0, 0, 0, 0, F_DIN);
		`SFD_OP_QPROG: decode = dsc(1, 0, 0, 2, 0, F_DIN);
		`SFD_OP_ERA4K, `SFD_OP_ERA32K, `SFD_OP_ERA64K: decode = dsc(1, 0, 0, 0, 0, F_TAIL);
		`SFD_OP_RD: decode = dsc(1, 0, 0, 0, 0, F_OUT);
		`SFD_OP_FRD: decode = dsc(1, 0, 0, 0, 8, F_OUT);
		`SFD_OP_FRD_DO: decode = dsc(1, 0, 0, 1, 8, F_OUT);
		`SFD_OP_FRD_QO: decode = dsc(1, 0, 0, 2, 8, F_OUT);
		`SFD_OP_FRD_DIO, `SFD_OP_ID_MF2: decode = dsc(1, 1, 1, 1, 0, F_OUT);
		`SFD_OP_FRD_QIO, `SFD_OP_ID_MF4: decode = dsc(1, 1, 2, 2, 4, F_OUT);
		`SFD_OP_WRD_QIO: decode = dsc(1, 1, 2, 2, 2, F_OUT);
		`SFD_OP_OWRD_QIO: decode = dsc(1, 1, 2, 2, 0, F_OUT);
		`SFD_OP_WRAP: decode = dsc(0, 0, 2, 0, 6, F_WRP);
		`SFD_OP_ID_REL, `SFD_OP_ID_MF: decode = dsc(0, 0, 0, 0, 24, F_OUT);
		`SFD_OP_JID: decode = dsc(0, 0, 0, 0, 0, F_OUT);
		default: decode = dsc(0, 0, 0, 0, 0, F_IGN);
		endcase
	end
endfunction

// phase that follows the current one; skipped phases fall through
function [9:0] nxt;
	input [9:0] cur;
	input       a;
	input       m;
	input [5:0] d;
	input [9:0] f;
	begin
		if (cur == S_OPC && a)
			nxt = S_ADR;
		else if ((cur == S_OPC || cur == S_ADR) && m)
			nxt = S_MOD;
		else if (cur != S_DUM && d != 6'd0)
			nxt = S_DUM;
		else
			nxt = f;
	end
endfunction

function [5:0] plen;
	input [9:0] s;
	input [1:0] aw;
	input [1:0] dw;
	input [5:0] d;
	begin
		case (s)
		S_ADR: plen = 6'd24 >> aw;
		S_MOD: plen = 6'd8 >> aw;
		S_DUM: plen = d;
		S_DIN, S_WSR: plen = 6'd8 >> dw;
		S_WRP: plen = 6'd1;
		default: plen = 6'd8;
		endcase
	end
endfunction

function [1:0] wof;
	input [9:0] s;
	input [1:0] aw;
	input [1:0] dw;
	begin
		case (s)
		S_ADR, S_MOD, S_DUM, S_WRP: wof = aw;
		S_DIN, S_WSR, S_OUT: wof = dw;
		default: wof = 2'd0;
		endcase
	end
endfunction

// region in 4KB sectors: n sectors at top or bottom, flipped when inverted
function prot_hit;
	input [15:0] s;
	input [7:0]  lo;
	input [7:0]  hi;
	reg   [8:0]  n;
	reg          top;
	begin
		case (s[`SFD_BP_HI:`SFD_BP_LO])
		3'd0: n = 9'd0;
		3'd1, 3'd2, 3'd3: n = s[`SFD_GRAN] ? (9'd1 << (s[3:2] - 2'd1)) : (9'd16 << (s[3:2] - 2'd1));
		3'd4: n = s[`SFD_GRAN] ? 9'd8 : 9'd128;
		3'd5: n = s[`SFD_GRAN] ? 9'd8 : 9'd256;
		default: n = 9'd256;
		endcase
		top = ~s[`SFD_TBOT];
		if (s[`SFD_INV]) begin
			n = 9'd256 - n;
			top = ~top;
		end
		if (n == 9'd0)
			prot_hit = 1'b0;
		else if (top)
			prot_hit = ({1'b0, hi} >= (9'd256 - n));
		else
			prot_hit = ({1'b0, lo} < n);
	end
endfunction

reg  [5:0]  s1_reg;
reg  [5:0]  s2_reg;
reg         sck_d_reg;
reg         csn_d_reg;
reg  [9:0]  st_reg;
reg  [5:0]  cnt_reg;
reg  [1:0]  w_reg;
reg  [2:0]  bits_reg;
reg  [23:0] acc_reg;
reg  [7:0]  op_reg;
reg         a_reg;
reg         m_reg;
reg  [1:0]  aw_reg;
reg  [1:0]  dw_reg;
reg  [5:0]  dum_reg;
reg  [9:0]  fin_reg;
reg  [23:0] addr_reg;
reg  [7:0]  cont_reg;
reg  [2:0]  wrap_reg;
reg  [7:0]  pcnt_reg;
reg  [7:0]  plast_reg;
reg  [7:0]  wlo_reg;
reg  [7:0]  osh_reg;
reg  [2:0]  ocnt_reg;
reg  [1:0]  oidx_reg;
reg  [3:0]  lo_reg;
reg  [3:0]  oe_reg;
reg  [15:0] nv_reg;
reg         wl_reg;
reg         vol_reg;
reg         busy_reg;
reg         sus_reg;
reg         pd_reg;
reg  [7:0]  pend_reg;
reg  [23:0] paddr_reg;
reg  [7:0]  fill_reg;
reg         ack_reg;
reg  [31:0] dat_reg;
reg  [7:0]  ob;
reg  [31:0] rd;

wire        rise   = s2_reg[4] & ~sck_d_reg & ~s2_reg[5];
wire        fall   = ~s2_reg[4] & sck_d_reg & ~s2_reg[5];
wire        cs_up  = s2_reg[5] & ~csn_d_reg;
wire [23:0] acc_next = shin(acc_reg, s2_reg[3:0], w_reg);
wire [15:0] dcd    = decode(acc_next[7:0]);
wire        in_opc = (st_reg == S_OPC);
wire [1:0]  n_aw   = in_opc ? dcd[13:12] : aw_reg;
wire [1:0]  n_dw   = in_opc ? dcd[11:10] : dw_reg;
wire [5:0]  n_dum  = in_opc ? dcd[9:4] : dum_reg;
wire [9:0]  d_fin  = 10'h001 << dcd[3:0];
wire [9:0]  ns     = in_opc ? nxt(S_OPC, dcd[15], dcd[14], dcd[9:4], d_fin) :
                     nxt(st_reg, a_reg, m_reg, dum_reg, fin_reg);
wire [15:0] stat   = {sus_reg, nv_reg[14:2], wl_reg, busy_reg};
wire        opn_st = (acc_next[7:0] == `SFD_OP_RD_ST1) || (acc_next[7:0] == `SFD_OP_RD_ST2);
wire        drop   = (pd_reg & (acc_next[7:0] != `SFD_OP_ID_REL)) | (busy_reg & ~opn_st);
wire        chip   = (op_reg == `SFD_OP_CHIP_A) || (op_reg == `SFD_OP_CHIP_B);
wire        e64    = (op_reg == `SFD_OP_ERA64K);
wire        e32    = (op_reg == `SFD_OP_ERA32K);
wire        era    = chip | e64 | e32 | (op_reg == `SFD_OP_ERA4K);
wire [7:0]  slo    = chip ? 8'h00 : e64 ? {addr_reg[19:16], 4'h0} :
                     e32 ? {addr_reg[19:15], 3'h0} : addr_reg[19:12];
wire [7:0]  shi    = chip ? 8'hFF : e64 ? {addr_reg[19:16], 4'hF} :
                     e32 ? {addr_reg[19:15], 3'h7} : addr_reg[19:12];
wire        hit    = prot_hit(stat, slo, shi);
wire        align  = (bits_reg == 3'd0);
wire        go     = align & wl_reg & ~hit & ~busy_reg &
                     (((st_reg == S_TAIL) & era) | ((st_reg == S_DIN) & (pcnt_reg != 8'd0)));
wire        two    = (pcnt_reg >= 8'd2);
wire [15:0] wsr_in = {two ? plast_reg : nv_reg[15:8], two ? wlo_reg : plast_reg};
wire        wb_req = wb_cyc_i & wb_stb_i;

assign quad_line_o      = lo_reg;
assign quad_line_oe_n_o = oe_reg;
assign wb_dat_o         = dat_reg;
assign wb_ack_o         = ack_reg;

always @* begin
	case (op_reg)
	`SFD_OP_RD_ST1: ob = stat[7:0];
	`SFD_OP_RD_ST2: ob = stat[15:8];
	`SFD_OP_ID_REL: ob = DEV_ID;
	`SFD_OP_ID_MF, `SFD_OP_ID_MF2, `SFD_OP_ID_MF4: ob = oidx_reg[0] ? DEV_ID : MFR_ID;
	`SFD_OP_JID: ob = (oidx_reg == 2'd0) ? MFR_ID :
	                  (oidx_reg == 2'd1) ? TYPE_CAP[15:8] : TYPE_CAP[7:0];
	default: ob = fill_reg;
	endcase
end

always @* begin
	case (wb_adr_i)
	`SFD_REG_OPC: rd = {8'h00, cont_reg, 1'b0, wrap_reg, wl_reg, pd_reg, sus_reg, busy_reg,
	                    pend_reg};
	`SFD_REG_ADDR: rd = {8'h00, paddr_reg};
	`SFD_REG_STAT: rd = {16'h0000, stat};
	`SFD_REG_FILL: rd = {8'h00, pcnt_reg, plast_reg, fill_reg};
	default: rd = 32'h0000_0000;
	endcase
end

always @(posedge clk_i) begin
	if (rst_i) begin
		s1_reg    <= `SFD_SYNC_RST;
		s2_reg    <= `SFD_SYNC_RST;
		sck_d_reg <= 1'b1;
		csn_d_reg <= 1'b1;
		st_reg    <= S_OPC;
		cnt_reg   <= 6'd8;
		w_reg     <= 2'd0;
		bits_reg  <= 3'd0;
		acc_reg   <= 24'h000000;
		op_reg    <= 8'h00;
		a_reg     <= 1'b0;
		m_reg     <= 1'b0;
		aw_reg    <= 2'd0;
		dw_reg    <= 2'd0;
		dum_reg   <= 6'd0;
		fin_reg   <= S_IGN;
		addr_reg  <= 24'h000000;
		cont_reg  <= 8'h00;
		wrap_reg  <= 3'd0;
		pcnt_reg  <= 8'h00;
		plast_reg <= 8'h00;
		wlo_reg   <= 8'h00;
		osh_reg   <= 8'h00;
		ocnt_reg  <= 3'd0;
		oidx_reg  <= 2'd0;
		lo_reg    <= 4'h0;
		oe_reg    <= 4'hF;
		nv_reg    <= `SFD_STAT_RST;
		wl_reg    <= 1'b0;
		vol_reg   <= 1'b0;
		busy_reg  <= 1'b0;
		sus_reg   <= 1'b0;
		pd_reg    <= 1'b0;
		pend_reg  <= 8'h00;
		paddr_reg <= 24'h000000;
		fill_reg  <= `SFD_FILL_RST;
		ack_reg   <= 1'b0;
		dat_reg   <= 32'h0000_0000;
	end else begin
		// pins pass two flops; edge logic only looks at the second stage
		s1_reg    <= {cs_n_i, sclk_i, quad_line_i};
		s2_reg    <= s1_reg;
		sck_d_reg <= s2_reg[4];
		csn_d_reg <= s2_reg[5];
		ack_reg   <= wb_req & ~ack_reg;
		if (wb_req & ~ack_reg)
			dat_reg <= rd;
		// writes land on the edge where the master sees ack
		if (wb_req & ack_reg & wb_we_i) begin
			if (wb_adr_i == `SFD_REG_CTRL && wb_sel_i[0] && wb_dat_i[`SFD_CTRL_DONE]) begin
				busy_reg <= 1'b0;
				wl_reg   <= 1'b0;
			end
			if (wb_adr_i == `SFD_REG_FILL && wb_sel_i[0])
				fill_reg <= wb_dat_i[7:0];
		end
		// link code comes after the bus so a latch set wins over a clear
		if (s2_reg[5]) begin
			if (cs_up && align) begin
				if (st_reg == S_TAIL) begin
					case (op_reg)
					`SFD_OP_WR_EN: wl_reg <= 1'b1;
					`SFD_OP_VOL_EN: vol_reg <= 1'b1;
					`SFD_OP_SUSP: sus_reg <= 1'b1;
					`SFD_OP_RESUME: sus_reg <= 1'b0;
					`SFD_OP_PDOWN: pd_reg <= 1'b1;
					default: ;
					endcase
					if (op_reg == `SFD_OP_WR_DIS) begin
						wl_reg  <= 1'b0;
						vol_reg <= 1'b0;
					end
				end
				if (go) begin
					busy_reg  <= 1'b1;
					pend_reg  <= op_reg;
					paddr_reg <= addr_reg;
				end
				if (st_reg == S_WSR && pcnt_reg != 8'd0 && (wl_reg | vol_reg)) begin
					nv_reg  <= (wsr_in & `SFD_WSR_MASK) | (nv_reg & `SFD_OTP_MASK);
					wl_reg  <= 1'b0;
					vol_reg <= 1'b0;
				end
			end
			st_reg   <= S_OPC;
			cnt_reg  <= 6'd8;
			w_reg    <= 2'd0;
			bits_reg <= 3'd0;
			oe_reg   <= 4'hF;
		end else if (rise) begin
			acc_reg  <= acc_next;
			bits_reg <= bits_reg + wbits(w_reg);
			if (cnt_reg != 6'd1) begin
				cnt_reg <= cnt_reg - 6'd1;
			end else begin
				case (st_reg)
				S_OPC, S_ADR, S_MOD, S_DUM: begin
					if (in_opc) begin
						op_reg   <= acc_next[7:0];
						a_reg    <= dcd[15];
						m_reg    <= dcd[14];
						aw_reg   <= dcd[13:12];
						dw_reg   <= dcd[11:10];
						dum_reg  <= dcd[9:4];
						fin_reg  <= d_fin;
						pcnt_reg <= 8'h00;
						oidx_reg <= 2'd0;
						ocnt_reg <= 3'd0;
						if (acc_next[7:0] == `SFD_OP_ID_REL)
							pd_reg <= 1'b0;
					end
					if (st_reg == S_ADR)
						addr_reg <= acc_next;
					if (st_reg == S_MOD)
						cont_reg <= acc_next[7:0];
					if (in_opc && drop) begin
						st_reg <= S_IGN;
					end else begin
						st_reg  <= ns;
						cnt_reg <= plen(ns, n_aw, n_dw, n_dum);
						w_reg   <= wof(ns, n_aw, n_dw);
						oe_reg  <= (ns != S_OUT) ? 4'hF : (n_dw == 2'd0) ? 4'hD :
						           (n_dw == 2'd1) ? 4'hC : 4'h0;
					end
				end
				S_WRP: begin
					wrap_reg <= acc_next[2:0];
					st_reg   <= S_TAIL;
					w_reg    <= 2'd0;
				end
				S_DIN, S_WSR: begin
					pcnt_reg  <= pcnt_reg + 8'd1;
					plast_reg <= acc_next[7:0];
					if (pcnt_reg == 8'd0)
						wlo_reg <= acc_next[7:0];
					cnt_reg <= plen(st_reg, aw_reg, dw_reg, dum_reg);
				end
				default: ;
				endcase
			end
		end else if (fall && st_reg == S_OUT) begin
			// a new byte loads when the last one is spent, so reads repeat freely
			if (ocnt_reg == 3'd0) begin
				lo_reg   <= obits(ob, dw_reg);
				osh_reg  <= shl(ob, dw_reg);
				ocnt_reg <= 3'd7 >> dw_reg;
				if (op_reg == `SFD_OP_JID && oidx_reg == 2'd2)
					oidx_reg <= 2'd0;
				else
					oidx_reg <= oidx_reg + 2'd1;
			end else begin
				lo_reg   <= obits(osh_reg, dw_reg);
				osh_reg  <= shl(osh_reg, dw_reg);
				ocnt_reg <= ocnt_reg - 3'd1;
			end
		end
	end
end

endmodule // sfd_core

// ### core/sfd_core_dummy_never.v
`timescale 1ns/1ps

// ### testbench/sfd_core_props.sv
`timescale 1ns/1ps
module sfd_core_props (
	input wire        clk_i,
	input wire        rst_i,
	input wire        cs_n_i,
	input wire [3:0]  quad_line_oe_n_o,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// cycles since select fell; saturates so long frames never wrap
	reg  [7:0] low_cnt;
	wire       req;
	assign req = wb_cyc_i && wb_stb_i;
	always @(posedge clk_i) begin
		if (rst_i || cs_n_i)
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hFF)
			low_cnt <= low_cnt + 8'h01;
	end
	AST_ACK_NEXT: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_IDLE: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");
	AST_RESET_QUIET: assert property ($fell(rst_i) |-> quad_line_oe_n_o == 4'hF
		&& !wb_ack_o && wb_dat_o == 32'h0)
		else $error("outputs not quiet after reset");
	AST_IDLE_RELEASE: assert property (cs_n_i [*5] |-> quad_line_oe_n_o == 4'hF)
		else $error("lines driven while deselected");
	AST_OPCODE_QUIET: assert property (low_cnt >= 8'h04 && low_cnt <= 8'h28
		|-> quad_line_oe_n_o == 4'hF)
		else $error("lines driven during opcode");
	AST_OE_CODES: assert property (quad_line_oe_n_o inside {4'hF, 4'hD, 4'hC, 4'h0})
		else $error("illegal enable pattern");
	AST_OE_HELD: assert property (!cs_n_i && quad_line_oe_n_o != 4'hF
		|=> $stable(quad_line_oe_n_o))
		else $error("enables changed inside frame");
	COV_SINGLE: cover property (quad_line_oe_n_o == 4'hD);
	COV_DUAL: cover property (quad_line_oe_n_o == 4'hC);
	COV_QUAD: cover property (quad_line_oe_n_o == 4'h0);
endmodule // sfd_core_props
bind sfd_core sfd_core_props u_props (
	.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .quad_line_oe_n_o(quad_line_oe_n_o),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// ### testbench/sfd_host_model.sv
`timescale 1ns/1ps
module sfd_host_model (
	input  wire       clk_i,
	input  wire [3:0] line_i,
	output reg        cs_n_o,
	output reg        sclk_o,
	output reg  [3:0] line_o,
	output reg  [3:0] line_en_o
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		line_o = 4'h0;
		line_en_o = 4'h0;
	end
	// low phase longer than high so output bits are settled at the rise
	task tick(input [3:0] d, input [3:0] en, output [3:0] s);
		begin
			sclk_o <= 1'b0;
			line_o <= d;
			line_en_o <= en;
			repeat (5) @(posedge clk_i);
			s = line_i;
			sclk_o <= 1'b1;
			repeat (3) @(posedge clk_i);
		end
	endtask
	task xb(input [7:0] d, input integer w, input rd, output [7:0] r);
		reg [3:0] s;
		reg [7:0] t;
		integer   i;
		begin
			t = d;
			r = 8'h00;
			for (i = 0; i < 8 / w; i = i + 1) begin
				tick(w == 1 ? {3'b000, t[7]} : w == 2 ? {2'b00, t[7:6]} : t[7:4],
					rd ? 4'h0 : (4'hF >> (4 - w)), s);
				t = t << w;
				r = w == 1 ? {r[6:0], s[1]} : w == 2 ? {r[5:0], s[1:0]} : {r[3:0], s};
			end
		end
	endtask
	task begin_f;
		begin
			cs_n_o <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
	endtask
	task end_f;
		begin
			sclk_o <= 1'b0;
			line_en_o <= 4'h0;
			repeat (3) @(posedge clk_i);
			cs_n_o <= 1'b1;
			repeat (8) @(posedge clk_i);
		end
	endtask
endmodule // sfd_host_model

// ### testbench/sfd_core_test.sv
`timescale 1ns/1ps
`include "sfd_map.vh"
module sfd_core_test;
	localparam [7:0]  MFR = 8'h6E;	// arbitrary value
	localparam [7:0]  DEV = 8'h21;	// arbitrary value
	localparam [15:0] TCP = 16'hB4D2;	// arbitrary value
	reg         clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg         wb_cyc_i = 1'b0;
	reg         wb_stb_i = 1'b0;
	reg         wb_we_i = 1'b0;
	reg  [7:0]  wb_adr_i = 8'h00;
	reg  [3:0]  wb_sel_i = 4'h0;
	reg  [31:0] wb_dat_i = 32'h0;
	reg         tog = 1'b0;
	wire        cs_n;
	wire        sclk;
	wire [3:0]  h_o;
	wire [3:0]  h_en;
	wire [3:0]  q_o;
	wire [3:0]  q_oe_n;
	wire [3:0]  lines;
	wire [31:0] wb_dat_o;
	wire        wb_ack_o;
	integer     failures = 0;
	integer     tests_run = 0;
	integer     cycles = 0;
	reg  [7:0]  r;
	reg  [31:0] v;
	reg  [3:0]  s;
	// released lines toggle so a stale value is never read as data
	assign lines = (~q_oe_n & q_o) | (q_oe_n & h_en & h_o) | (q_oe_n & ~h_en & {4{tog}});
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		tog <= ~tog;
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			failures = failures + 1;
			report_and_stop;
		end
	end
	sfd_core #(.MFR_ID(MFR), .DEV_ID(DEV), .TYPE_CAP(TCP)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
		.quad_line_i(lines), .quad_line_o(q_o), .quad_line_oe_n_o(q_oe_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
	);
	sfd_host_model u_host (
		.clk_i(clk_i), .line_i(lines), .cs_n_o(cs_n), .sclk_o(sclk),
		.line_o(h_o), .line_en_o(h_en)
	);
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", tests_run, failures);
			if (failures == 0 && tests_run > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input string n, input [31:0] e, input [31:0] g);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("wrong value %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
		begin
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_dat_i <= d;
			wb_sel_i <= 4'hF;
			@(posedge clk_i);
			while (wb_ack_o !== 1'b1)
				@(posedge clk_i);
			q = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	task op1(input [7:0] o);
		begin
			u_host.begin_f;
			u_host.xb(o, 1, 0, r);
			u_host.end_f;
		end
	endtask
	task ad(input [23:0] a, input integer w);
		begin
			u_host.xb(a[23:16], w, 0, r);
			u_host.xb(a[15:8], w, 0, r);
			u_host.xb(a[7:0], w, 0, r);
		end
	endtask
	task rd1(input [7:0] o, input [7:0] e);
		begin
			u_host.begin_f;
			u_host.xb(o, 1, 0, r);
			u_host.xb(8'h00, 1, 1, r);
			chk("status byte", e, r);
			u_host.end_f;
		end
	endtask
	task setst(input [7:0] lo, input [7:0] hi);
		begin
			op1(`SFD_OP_WR_EN);
			u_host.begin_f;
			u_host.xb(`SFD_OP_WR_ST, 1, 0, r);
			u_host.xb(lo, 1, 0, r);
			u_host.xb(hi, 1, 0, r);
			u_host.end_f;
		end
	endtask
	task erase(input [7:0] o, input na, input [23:0] a, input eb);
		begin
			op1(`SFD_OP_WR_EN);
			u_host.begin_f;
			u_host.xb(o, 1, 0, r);
			if (na)
				ad(a, 1);
			u_host.end_f;
			wb(0, `SFD_REG_OPC, 0, v);
			chk("erase busy", eb, v[8]);
			if (eb) begin
				chk("erase op", o, v[7:0]);
				wb(1, `SFD_REG_CTRL, 1, v);
			end
		end
	endtask
	task prog(input [7:0] o, input integer w, input [7:0] dt);
		begin
			op1(`SFD_OP_WR_EN);
			u_host.begin_f;
			u_host.xb(o, 1, 0, r);
			ad(24'h000100, 1);
			u_host.xb(dt, w, 0, r);
			u_host.end_f;
			wb(0, `SFD_REG_FILL, 0, v);
			chk("prog byte", dt, v[15:8]);
			chk("prog count", 1, v[23:16]);
			wb(0, `SFD_REG_OPC, 0, v);
			chk("prog busy", 1, v[8]);
		end
	endtask
	task rd(input [7:0] o, input integer aw, input integer dn, input integer dw,
		input [7:0] e0, input [7:0] e1, input [7:0] e2);
		integer i;
		begin
			u_host.begin_f;
			u_host.xb(o, 1, 0, r);
			if (aw > 0)
				ad(24'h012340, aw);
			if (aw > 1)
				u_host.xb(8'h00, aw, 0, r);
			for (i = 0; i < dn; i = i + 1)
				u_host.tick(4'h0, 4'h0, s);
			u_host.xb(8'h00, dw, 1, r);
			chk("read 0", e0, r);
			u_host.xb(8'h00, dw, 1, r);
			chk("read 1", e1, r);
			u_host.xb(8'h00, dw, 1, r);
			chk("read 2", e2, r);
			u_host.end_f;
		end
	endtask
	task t_reset;
		begin
			wb(0, `SFD_REG_STAT, 0, v);
			chk("status", 32'h0, v);
			wb(0, `SFD_REG_FILL, 0, v);
			chk("fill", 32'hFF, v[7:0]);
			wb(0, 8'h20, 0, v);
			chk("unmapped", 32'h0, v);
			$display("test reset done");
		end
	endtask
	task t_latch;
		begin
			op1(`SFD_OP_WR_EN);
			wb(0, `SFD_REG_STAT, 0, v);
			chk("latch set", 1, v[1]);
			u_host.begin_f;
			u_host.xb(`SFD_OP_RD_ST1, 1, 0, r);
			repeat (3) begin
				u_host.xb(8'h00, 1, 1, r);
				chk("status repeat", 8'h02, r);
			end
			u_host.end_f;
			u_host.begin_f;
			u_host.xb(`SFD_OP_RD_ST1, 1, 0, r);
			repeat (3) u_host.tick(4'h0, 4'h0, s);
			u_host.end_f;
			rd1(`SFD_OP_RD_ST2, 8'h00);
			op1(`SFD_OP_WR_DIS);
			op1(`SFD_OP_VOL_EN);
			wb(0, `SFD_REG_STAT, 0, v);
			chk("latch clear", 0, v[1]);
			u_host.begin_f;
			repeat (5) u_host.tick(4'h1, 4'h1, s);
			u_host.end_f;
			op1(`SFD_OP_WR_EN);
			wb(0, `SFD_REG_STAT, 0, v);
			chk("after partial", 1, v[1]);
			u_host.begin_f;
			u_host.xb(`SFD_OP_ERA4K, 1, 0, r);
			ad(24'h001000, 1);
			repeat (3) u_host.tick(4'h0, 4'h1, s);
			u_host.end_f;
			wb(0, `SFD_REG_OPC, 0, v);
			chk("odd bits", 0, v[8]);
			$display("test latch done");
		end
	endtask
	task t_protect;
		begin
			setst(8'h00, 8'h40);
			erase(`SFD_OP_ERA4K, 1, 24'h000000, 0);
			setst(8'h04, 8'h40);
			erase(`SFD_OP_ERA64K, 1, 24'h0F0000, 1);
			erase(`SFD_OP_ERA64K, 1, 24'h0E0000, 0);
			erase(`SFD_OP_CHIP_A, 0, 24'h0, 0);
			setst(8'h44, 8'h40);
			erase(`SFD_OP_ERA4K, 1, 24'h0FF000, 1);
			erase(`SFD_OP_ERA32K, 1, 24'h0F8000, 0);
			setst(8'h24, 8'h40);
			erase(`SFD_OP_ERA4K, 1, 24'h000000, 1);
			erase(`SFD_OP_ERA4K, 1, 24'h010000, 0);
			setst(8'h04, 8'h00);
			erase(`SFD_OP_ERA64K, 1, 24'h0E0000, 1);
			setst(8'h1C, 8'h40);
			erase(`SFD_OP_CHIP_A, 0, 24'h0, 1);
			erase(`SFD_OP_CHIP_B, 0, 24'h0, 1);
			rd1(`SFD_OP_RD_ST2, 8'h40);
			wb(0, `SFD_REG_STAT, 0, v);
			chk("status word", 16'h401C, v[15:0]);
			$display("test protect done");
		end
	endtask
	task t_prog;
		begin
			prog(`SFD_OP_PROG, 1, 8'hA5);
			op1(`SFD_OP_WR_DIS);
			op1(`SFD_OP_SUSP);
			rd1(`SFD_OP_RD_ST1, 8'h1F);
			wb(0, `SFD_REG_OPC, 0, v);
			chk("no suspend", 0, v[9]);
			wb(1, `SFD_REG_CTRL, 1, v);
			wb(0, `SFD_REG_STAT, 0, v);
			chk("done status", 16'h401C, v[15:0]);
			prog(`SFD_OP_QPROG, 4, 8'h96);
			wb(1, `SFD_REG_CTRL, 1, v);
			op1(`SFD_OP_PDOWN);
			wb(0, `SFD_REG_OPC, 0, v);
			chk("power down", 1, v[10]);
			op1(`SFD_OP_RESUME);
			op1(`SFD_OP_ID_REL);
			wb(0, `SFD_REG_OPC, 0, v);
			chk("released", 0, v[10]);
			op1(`SFD_OP_SUSP);
			rd1(`SFD_OP_RD_ST2, 8'hC0);
			op1(`SFD_OP_RESUME);
			wb(0, `SFD_REG_OPC, 0, v);
			chk("resumed", 0, v[9]);
			$display("test program done");
		end
	endtask
	task t_reads;
		begin
			wb(1, `SFD_REG_FILL, 32'hC5, v);
			u_host.begin_f;
			u_host.xb(`SFD_OP_CRM_RST, 1, 0, r);
			u_host.xb(`SFD_OP_CRM_RST, 1, 0, r);
			u_host.end_f;
			rd(`SFD_OP_RD, 1, 0, 1, 8'hC5, 8'hC5, 8'hC5);
			rd(`SFD_OP_FRD, 1, 8, 1, 8'hC5, 8'hC5, 8'hC5);
			rd(`SFD_OP_FRD_DO, 1, 8, 2, 8'hC5, 8'hC5, 8'hC5);
			rd(`SFD_OP_FRD_QO, 1, 8, 4, 8'hC5, 8'hC5, 8'hC5);
			rd(`SFD_OP_FRD_DIO, 2, 0, 2, 8'hC5, 8'hC5, 8'hC5);
			rd(`SFD_OP_FRD_QIO, 4, 4, 4, 8'hC5, 8'hC5, 8'hC5);
			rd(`SFD_OP_WRD_QIO, 4, 2, 4, 8'hC5, 8'hC5, 8'hC5);
			rd(`SFD_OP_OWRD_QIO, 4, 0, 4, 8'hC5, 8'hC5, 8'hC5);
			rd(`SFD_OP_ID_REL, 1, 0, 1, DEV, DEV, DEV);
			rd(`SFD_OP_ID_MF, 1, 0, 1, MFR, DEV, MFR);
			rd(`SFD_OP_ID_MF2, 2, 0, 2, MFR, DEV, MFR);
			rd(`SFD_OP_ID_MF4, 4, 4, 4, MFR, DEV, MFR);
			rd(`SFD_OP_JID, 0, 0, 1, MFR, TCP[15:8], TCP[7:0]);
			u_host.begin_f;
			u_host.xb(`SFD_OP_WRAP, 1, 0, r);
			repeat (3) u_host.xb(8'h00, 4, 0, r);
			u_host.xb(8'h50, 4, 0, r);
			u_host.end_f;
			wb(0, `SFD_REG_OPC, 0, v);
			chk("wrap length", 3'h5, v[14:12]);
			$display("test reads done");
		end
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_reset;
		t_latch;
		t_protect;
		t_prog;
		t_reads;
		report_and_stop;
	end
endmodule // sfd_core_test
